//--- glc_gamma_checker.sv
// port checks for the gamma corrector
// assumes latency 6 and plane select tied low in parallel builds; bound to every corrector
`timescale 1ns/10ps
`include "glc_gamma_defines.vh"
module glc_gamma_checker #(
    parameter DATA_W = 8,
    parameter CE_EN = 0,
    parameter SR_EN = 0
) (
    // clock and controls
    input wire MCLK,
    input wire RST_N,
    input wire CE,
    input wire SYNC_CLEAR_IN,
    // stream
    input wire [DATA_W-1:0] PLANE_A_SAMPLE_IN,
    input wire SAMPLE_VALID_IN,
    input wire CORR_EN_IN,
    input wire [1:0] PLANE_SEL_IN,
    input wire [DATA_W-1:0] PLANE_A_RESULT_OUT,
    input wire RESULT_VALID_OUT,
    input wire CORRECTED_OUT,
    input wire [1:0] PLANE_SEL_OUT,
    // apb
    input wire PSEL,
    input wire PENABLE,
    input wire [7:0] PADDR,
    input wire PREADY,
    input wire PSLVERR
);
    wire run = (CE_EN == 0 || CE) && (SR_EN == 0 || !SYNC_CLEAR_IN);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    // six active edges carry a sample to the output
    sequence took_s(v);
        (v && run) ##1 run [*5];
    endsequence
    lat_valid_a: assert property (took_s(SAMPLE_VALID_IN) |=> RESULT_VALID_OUT)
        else $error("result valid missing after latency");
    no_phantom_a: assert property (took_s(!SAMPLE_VALID_IN) |=> !RESULT_VALID_OUT)
        else $error("result valid without a valid sample");
    bypass_data_a: assert property (took_s(SAMPLE_VALID_IN && !CORR_EN_IN) |=>
        !CORRECTED_OUT && PLANE_A_RESULT_OUT == $past(PLANE_A_SAMPLE_IN, 6))
        else $error("bypassed sample not forwarded");
    corr_cause_a: assert property (run [*6] ##1 (RESULT_VALID_OUT && CORRECTED_OUT)
        |-> $past(CORR_EN_IN, 6))
        else $error("corrected flag without enable");
    sel_order_a: assert property (took_s(SAMPLE_VALID_IN) |=>
        PLANE_SEL_OUT == $past(PLANE_SEL_IN, 6))
        else $error("plane order broken");
    freeze_a: assert property (CE_EN == 1 && !CE && !SYNC_CLEAR_IN |=>
        $stable(RESULT_VALID_OUT) && $stable(PLANE_A_RESULT_OUT) && $stable(PLANE_SEL_OUT))
        else $error("state moved while clock enable low");
    clear_drop_a: assert property (SR_EN == 1 && SYNC_CLEAR_IN |=> !RESULT_VALID_OUT)
        else $error("result valid after clear");
    ready_time_a: assert property (PSEL && !PENABLE ##1 PSEL && PENABLE |=> PREADY)
        else $error("ready late");
    ready_pulse_a: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    unmapped_err_a: assert property (PSEL && PENABLE && PREADY |->
        PSLVERR == !(PADDR[1:0] == 2'h0 && PADDR <= `GLC_OFF_VALID_COUNT))
        else $error("error response wrong");
    cover property (RESULT_VALID_OUT && CORRECTED_OUT);
    cover property (RESULT_VALID_OUT && !CORRECTED_OUT);
    cover property (PREADY && PSLVERR);
endmodule
bind glc_gamma_corrector glc_gamma_checker #(.DATA_W(DATA_W), .CE_EN(CE_EN), .SR_EN(SR_EN))
    u_chk (.MCLK(MCLK), .RST_N(RST_N), .CE(CE), .SYNC_CLEAR_IN(SYNC_CLEAR_IN),
    .PLANE_A_SAMPLE_IN(PLANE_A_SAMPLE_IN), .SAMPLE_VALID_IN(SAMPLE_VALID_IN),
    .CORR_EN_IN(CORR_EN_IN), .PLANE_SEL_IN(PLANE_SEL_IN),
    .PLANE_A_RESULT_OUT(PLANE_A_RESULT_OUT), .RESULT_VALID_OUT(RESULT_VALID_OUT),
    .CORRECTED_OUT(CORRECTED_OUT), .PLANE_SEL_OUT(PLANE_SEL_OUT), .PSEL(PSEL),
    .PENABLE(PENABLE), .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR));

//--- glc_gamma_corrector.v
// gamma look-up corrector for up to three colour planes, apb register slave
// assumes upstream pixel logic and an apb master on the same clock MCLK
//
// What this block does
// - after fixed latency, results appear with result valid high.
// - correction enabled: output table value and corrected flag high.
// - correction disabled: forward input unchanged, corrected flag low.
// - sequential results leave in consecutive cycles in input order.
// - plane count is a build parameter, 1 to 3, default 3.
// - optional setting makes all planes copy plane a width and gamma.
// - architecture is parallel or sequential, default sequential.
// - sample width 4 to 12, default 8; one table entry per code.
// - table built from gamma exponent 0.1 to 10.0, default 2.2.
// - table contents filled from address 0 in increasing order.
// - build option allows rewriting the table at run time.
// - bypass option adds enable input and corrected flag; default on.
// - registered input option captures the stream inputs first, using one of the latency stages.
// - memory style sets the reported block or distributed choice by width; storage is one plain array.
// - total latency is 4, 5 or 6 cycles, default 6.
// - clock enable exists only when built in; default off.
// - synchronous clear exists only when built in; default off.
// - clock enable low ignores stream inputs and freezes the pipeline; apb accesses still act.
// - synchronous clear empties the pipeline registers and drops result valid; table, control and count keep values.
// - table write strobe stores write value at the sample address.
// - narrower planes are msb aligned with zero low bits.
`timescale 1ns/10ps
`include "glc_gamma_defines.vh"

module glc_gamma_corrector #(
    parameter NUM_PLANES = 3,
    parameter SEQ_ARCH = 1,
    parameter SAME_PLANES = 1,
    parameter DATA_W = 8,
    parameter PLANE_B_W = 8,
    parameter PLANE_C_W = 8,
    parameter real GAMMA_A = 2.2,
    parameter real GAMMA_B = 2.2,
    parameter real GAMMA_C = 2.2,
    parameter PROG_LUT = 1,
    parameter BYPASS_EN = 1,
    parameter REG_INPUT = 1,
    parameter MEM_STYLE = `GLC_MEM_AUTO,
    parameter LATENCY = 6,
    parameter CE_EN = 0,
    parameter SR_EN = 0
) (
    // clock, reset, options
    input wire MCLK,
    input wire RST_N,
    input wire CE,
    input wire SYNC_CLEAR_IN,
    // samples in
    input wire [DATA_W-1:0] PLANE_A_SAMPLE_IN,
    input wire [DATA_W-1:0] PLANE_B_SAMPLE_IN,
    input wire [DATA_W-1:0] PLANE_C_SAMPLE_IN,
    input wire SAMPLE_VALID_IN,
    input wire CORR_EN_IN,
    input wire [1:0] PLANE_SEL_IN,
    // table loading
    input wire [DATA_W-1:0] TABLE_WRITE_VALUE_A,
    input wire [DATA_W-1:0] TABLE_WRITE_VALUE_B,
    input wire [DATA_W-1:0] TABLE_WRITE_VALUE_C,
    input wire TABLE_WRITE_STROBE_A,
    input wire TABLE_WRITE_STROBE_B,
    input wire TABLE_WRITE_STROBE_C,
    // results out
    output reg [DATA_W-1:0] PLANE_A_RESULT_OUT,
    output reg [DATA_W-1:0] PLANE_B_RESULT_OUT,
    output reg [DATA_W-1:0] PLANE_C_RESULT_OUT,
    output reg RESULT_VALID_OUT,
    output reg CORRECTED_OUT,
    output reg [1:0] PLANE_SEL_OUT,
    // apb slave
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR
);

    localparam DEPTH = 1 << DATA_W;
    localparam LW = 3 * DATA_W;
    localparam PKW = LW + 3;
    localparam PAD = LATENCY - 2 - REG_INPUT;
    // informational only; the table itself is a plain array either way
    localparam MEM_BLOCK = (MEM_STYLE == `GLC_MEM_BLOCK) ? (DATA_W >= `GLC_BLOCK_MIN_W) :
        (MEM_STYLE == `GLC_MEM_DIST) ? (DATA_W > `GLC_DIST_MAX_W) :
        (DATA_W >= `GLC_AUTO_BLOCK_MIN_W);
    reg [DATA_W-1:0] lut_mem [0:3*DEPTH-1];
    function integer plane_w;
        input integer p;
        begin
            plane_w = (SAME_PLANES != 0 || p == 0) ? DATA_W :
                (p == 1) ? PLANE_B_W : PLANE_C_W;
        end
    endfunction
    // narrow planes live in the upper bits, so the table address is the top bits
    function [DATA_W+1:0] lut_idx;
        input [1:0] p;
        input [DATA_W-1:0] s;
        begin
            lut_idx = {p, s >> (DATA_W - plane_w(p))};
        end
    endfunction
    function [DATA_W-1:0] align;
        input [1:0] p;
        input [DATA_W-1:0] v;
        begin
            align = (v >> (DATA_W - plane_w(p))) << (DATA_W - plane_w(p));
        end
    endfunction
    function real r_ln;
        input real x;
        integer k;
        integer m;
        real y;
        real z;
        real t;
        real s;
        begin
            y = x;
            m = 0;
            for (k = 0; k < 40; k = k + 1) begin
                if (y < 0.5) begin
                    y = y * 2.0;
                    m = m + 1;
                end
            end
            z = (y - 1.0) / (y + 1.0);
            t = z;
            s = 0.0;
            for (k = 0; k < 30; k = k + 1) begin
                s = s + t / (2 * k + 1);
                t = t * z * z;
            end
            r_ln = 2.0 * s - m * `GLC_LN2;
        end
    endfunction
    // range reduced series keeps precision for large negative arguments
    function real r_exp;
        input real y;
        integer k;
        real t;
        real s;
        real term;
        begin
            t = y / 256.0;
            s = 1.0;
            term = 1.0;
            for (k = 1; k < 15; k = k + 1) begin
                term = term * t / k;
                s = s + term;
            end
            for (k = 0; k < 8; k = k + 1)
                s = s * s;
            r_exp = s;
        end
    endfunction
    // power-up table contents from the gamma exponent
    initial begin : gamma_fill
        integer p;
        integer a;
        integer mx;
        integer iv;
        real g;
        for (p = 0; p < 3; p = p + 1) begin
            mx = (1 << plane_w(p)) - 1;
            g = (SAME_PLANES != 0 || p == 0) ? GAMMA_A : (p == 1) ? GAMMA_B : GAMMA_C;
            for (a = 0; a < DEPTH; a = a + 1) begin
                if (a == 0 || a > mx)
                    iv = 0;
                else
                    iv = $rtoi(mx * r_exp(r_ln(a / (mx * 1.0)) / g) + 0.5);
                iv = iv << (DATA_W - plane_w(p));
                lut_mem[p*DEPTH+a] = iv[DATA_W-1:0];
            end
        end
    end

    // control and apb state
    reg [1:0] ctrl_reg;
    reg [31:0] count_reg;
    wire ce_act = (CE_EN == 0) | CE;
    wire clr = ~RST_N | ((SR_EN != 0) & SYNC_CLEAR_IN) | ctrl_reg[`GLC_CTRL_CLEAR_BIT];
    wire apb_acc = PSEL & PENABLE & ~PREADY;
    wire apb_fire = PSEL & PENABLE & PREADY & PWRITE;
    wire apb_map = (PADDR == `GLC_OFF_CONFIG) | (PADDR == `GLC_OFF_CONTROL) |
        (PADDR == `GLC_OFF_TABLE_WRITE) | (PADDR == `GLC_OFF_VALID_COUNT);

    // input stage
    reg [LW-1:0] in_smp_reg;
    reg [LW-1:0] in_wv_reg;
    reg [2:0] in_ws_reg;
    reg in_val_reg;
    reg in_gc_reg;
    reg [1:0] in_tag_reg;
    wire [LW-1:0] port_smp = {PLANE_C_SAMPLE_IN, PLANE_B_SAMPLE_IN, PLANE_A_SAMPLE_IN};
    wire [LW-1:0] port_wv = {TABLE_WRITE_VALUE_C, TABLE_WRITE_VALUE_B, TABLE_WRITE_VALUE_A};
    wire [2:0] port_ws = {TABLE_WRITE_STROBE_C, TABLE_WRITE_STROBE_B, TABLE_WRITE_STROBE_A};
    // registering costs one of the latency stages but eases input timing
    wire [LW-1:0] s_smp = REG_INPUT ? in_smp_reg : port_smp;
    wire [LW-1:0] s_wv = REG_INPUT ? in_wv_reg : port_wv;
    wire [2:0] s_ws = REG_INPUT ? in_ws_reg : port_ws;
    wire s_val = REG_INPUT ? in_val_reg : SAMPLE_VALID_IN;
    wire s_gc_in = REG_INPUT ? in_gc_reg : CORR_EN_IN;
    wire [1:0] s_tag = REG_INPUT ? in_tag_reg : PLANE_SEL_IN;
    wire s_gc = (BYPASS_EN == 0) | (s_gc_in & ~ctrl_reg[`GLC_CTRL_BYPASS_BIT]);

    always @(posedge MCLK) begin
        if (clr) begin
            in_smp_reg <= {LW{1'b0}};
            in_wv_reg <= {LW{1'b0}};
            in_ws_reg <= 3'h0;
            in_val_reg <= 1'b0;
            in_gc_reg <= 1'b0;
            in_tag_reg <= 2'h0;
        end else if (ce_act) begin
            in_smp_reg <= port_smp;
            in_wv_reg <= port_wv;
            in_ws_reg <= port_ws;
            in_val_reg <= SAMPLE_VALID_IN;
            in_gc_reg <= CORR_EN_IN;
            in_tag_reg <= PLANE_SEL_IN;
        end
    end

    // table writes from the ports and from apb
    always @(posedge MCLK) begin : table_wr
        integer k;
        reg [1:0] pl;
        pl = 2'h0;
        if (PROG_LUT != 0 && ce_act && !clr) begin
            for (k = 0; k < 3; k = k + 1) begin
                pl = SEQ_ARCH ? s_tag : k[1:0];
                if (s_ws[k] && (SEQ_ARCH ? k == 0 : k < NUM_PLANES))
                    lut_mem[lut_idx(pl, s_smp[k*DATA_W +: DATA_W])] <=
                        align(pl, s_wv[k*DATA_W +: DATA_W]);
            end
        end
        if (PROG_LUT != 0 && apb_fire && PADDR == `GLC_OFF_TABLE_WRITE &&
            PWDATA[`GLC_TW_PLANE_LSB +: 2] < NUM_PLANES) begin
            pl = PWDATA[`GLC_TW_PLANE_LSB +: 2];
            lut_mem[lut_idx(pl, PWDATA[`GLC_TW_ADDR_LSB +: DATA_W])] <=
                align(pl, PWDATA[`GLC_TW_VAL_LSB +: DATA_W]);
        end
    end
    // lookup stage
    reg [LW-1:0] rd_dat_reg;
    reg rd_val_reg;
    reg rd_gc_reg;
    reg [1:0] rd_tag_reg;
    always @(posedge MCLK) begin : lookup
        integer k;
        reg [1:0] pl;
        reg [DATA_W-1:0] smp;
        pl = 2'h0;
        smp = {DATA_W{1'b0}};
        if (clr) begin
            rd_dat_reg <= {LW{1'b0}};
            rd_val_reg <= 1'b0;
            rd_gc_reg <= 1'b0;
            rd_tag_reg <= 2'h0;
        end else if (ce_act) begin
            for (k = 0; k < 3; k = k + 1) begin
                pl = SEQ_ARCH ? s_tag : k[1:0];
                smp = s_smp[k*DATA_W +: DATA_W];
                if (SEQ_ARCH ? k != 0 : k >= NUM_PLANES)
                    rd_dat_reg[k*DATA_W +: DATA_W] <= {DATA_W{1'b0}};
                else if (s_gc)
                    rd_dat_reg[k*DATA_W +: DATA_W] <= lut_mem[lut_idx(pl, smp)];
                else
                    rd_dat_reg[k*DATA_W +: DATA_W] <= smp;
            end
            rd_val_reg <= s_val;
            rd_gc_reg <= s_gc;
            rd_tag_reg <= SEQ_ARCH ? s_tag : 2'h0;
        end
    end

    // padding delay so the total latency matches the build setting
    reg [PKW-1:0] dl_reg [0:PAD-1];
    reg [PAD-1:0] dl_v_reg;
    always @(posedge MCLK) begin : delay
        integer k;
        if (clr) begin
            dl_v_reg <= {PAD{1'b0}};
            for (k = 0; k < PAD; k = k + 1)
                dl_reg[k] <= {PKW{1'b0}};
        end else if (ce_act) begin
            dl_v_reg[0] <= rd_val_reg;
            dl_reg[0] <= {rd_tag_reg, rd_gc_reg, rd_dat_reg};
            for (k = 1; k < PAD; k = k + 1) begin
                dl_v_reg[k] <= dl_v_reg[k-1];
                dl_reg[k] <= dl_reg[k-1];
            end
        end
    end

    // output stage
    wire [PKW-1:0] last = dl_reg[PAD-1];
    always @(posedge MCLK) begin
        if (clr) begin
            PLANE_A_RESULT_OUT <= {DATA_W{1'b0}};
            PLANE_B_RESULT_OUT <= {DATA_W{1'b0}};
            PLANE_C_RESULT_OUT <= {DATA_W{1'b0}};
            RESULT_VALID_OUT <= 1'b0;
            CORRECTED_OUT <= 1'b0;
            PLANE_SEL_OUT <= 2'h0;
        end else if (ce_act) begin
            PLANE_A_RESULT_OUT <= last[0 +: DATA_W];
            PLANE_B_RESULT_OUT <= last[DATA_W +: DATA_W];
            PLANE_C_RESULT_OUT <= last[2*DATA_W +: DATA_W];
            RESULT_VALID_OUT <= dl_v_reg[PAD-1];
            CORRECTED_OUT <= last[LW];
            PLANE_SEL_OUT <= last[LW+1 +: 2];
        end
    end

    // apb slave: one wait state, pready is a one-cycle pulse
    reg [31:0] rd_word;
    always @* begin
        rd_word = `GLC_WORD_ZERO;
        case (PADDR)
            `GLC_OFF_CONFIG: begin
                rd_word[`GLC_CFG_SEQ_BIT] = (SEQ_ARCH != 0);
                rd_word[`GLC_CFG_PLANES_LSB +: 2] = NUM_PLANES[1:0];
                rd_word[`GLC_CFG_LAT_LSB +: 3] = LATENCY[2:0];
                rd_word[`GLC_CFG_WIDTH_LSB +: 4] = DATA_W[3:0];
                rd_word[`GLC_CFG_BLOCK_BIT] = (MEM_BLOCK != 0);
                rd_word[`GLC_CFG_PROG_BIT] = (PROG_LUT != 0);
                rd_word[`GLC_CFG_BYPASS_BIT] = (BYPASS_EN != 0);
            end
            `GLC_OFF_CONTROL: rd_word[1:0] = ctrl_reg;
            `GLC_OFF_VALID_COUNT: rd_word = count_reg;
            default: rd_word = `GLC_WORD_ZERO;
        endcase
    end

    always @(posedge MCLK) begin
        if (!RST_N) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= `GLC_WORD_ZERO;
            ctrl_reg <= `GLC_CTRL_RESET;
            count_reg <= `GLC_COUNT_RESET;
        end else begin
            PREADY <= apb_acc;
            PSLVERR <= apb_acc & ~apb_map;
            if (apb_acc && !PWRITE)
                PRDATA <= apb_map ? rd_word : `GLC_WORD_ZERO;
            if (apb_fire && PADDR == `GLC_OFF_CONTROL)
                ctrl_reg <= PWDATA[1:0];
            if (ce_act && !clr && dl_v_reg[PAD-1])
                count_reg <= count_reg + 32'h0000_0001;
        end
    end

endmodule

//--- glc_gamma_corrector_tb.sv
// self-checking bench for the gamma corrector, sequential and parallel three-plane builds
// assumes the pixel source model and the bound checker
`timescale 1ns/10ps
`include "glc_gamma_defines.vh"
module glc_gamma_corrector_tb;
    reg mclk;
    reg rst_n = 1'b0;
    reg ce = 1'b1;
    reg clr = 1'b0;
    reg go = 1'b0;
    reg wr_b = 1'b0;
    reg corr_b = 1'b0;
    reg [7:0] base_b = 8'h00;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0000_0000;
    reg [31:0] q;
    reg e;
    wire [7:0] smp, wval, res_a, res_b, res_c, par_a, par_b, par_c;
    wire [1:0] sel, sel_out, par_sel;
    wire vld, stb, cen, rvld, corr_out, pready, pslverr, pvld, pcorr;
    wire [26:0] par_all = {par_sel, par_c, par_b, par_a, pcorr};
    wire [31:0] prdata;
    integer n_fail = 0;
    integer n_checks = 0;
    glc_pixel_source src (.clk(mclk), .go(go), .wr(wr_b), .corr(corr_b), .base(base_b),
        .sample(smp), .sel(sel), .valid(vld), .strobe(stb), .wval(wval), .corr_en(cen));
    glc_gamma_corrector #(.CE_EN(1), .SR_EN(1)) dut (.MCLK(mclk), .RST_N(rst_n), .CE(ce),
        .SYNC_CLEAR_IN(clr), .PLANE_A_SAMPLE_IN(smp), .PLANE_B_SAMPLE_IN(smp),
        .PLANE_C_SAMPLE_IN(smp), .SAMPLE_VALID_IN(vld), .CORR_EN_IN(cen), .PLANE_SEL_IN(sel),
        .TABLE_WRITE_VALUE_A(wval), .TABLE_WRITE_VALUE_B(wval), .TABLE_WRITE_VALUE_C(wval),
        .TABLE_WRITE_STROBE_A(stb), .TABLE_WRITE_STROBE_B(1'b0), .TABLE_WRITE_STROBE_C(1'b0),
        .PLANE_A_RESULT_OUT(res_a), .PLANE_B_RESULT_OUT(res_b), .PLANE_C_RESULT_OUT(res_c),
        .RESULT_VALID_OUT(rvld), .CORRECTED_OUT(corr_out), .PLANE_SEL_OUT(sel_out),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
    // parallel build sees three distinct planes in the same cycle
    glc_gamma_corrector #(.SEQ_ARCH(0)) dut_par (.MCLK(mclk), .RST_N(rst_n), .CE(ce),
        .SYNC_CLEAR_IN(clr), .PLANE_A_SAMPLE_IN(smp), .PLANE_B_SAMPLE_IN(~smp),
        .PLANE_C_SAMPLE_IN(smp ^ 8'hEF), .SAMPLE_VALID_IN(vld), .CORR_EN_IN(cen),
        .PLANE_SEL_IN(2'h0), .TABLE_WRITE_VALUE_A(wval), .TABLE_WRITE_VALUE_B(wval),
        .TABLE_WRITE_VALUE_C(wval), .TABLE_WRITE_STROBE_A(1'b0), .TABLE_WRITE_STROBE_B(1'b0),
        .TABLE_WRITE_STROBE_C(1'b0), .PLANE_A_RESULT_OUT(par_a), .PLANE_B_RESULT_OUT(par_b),
        .PLANE_C_RESULT_OUT(par_c), .RESULT_VALID_OUT(pvld), .CORRECTED_OUT(pcorr),
        .PLANE_SEL_OUT(par_sel), .PSEL(1'b0), .PENABLE(1'b0), .PWRITE(1'b0), .PADDR(8'h00),
        .PWDATA(32'h0000_0000), .PRDATA(), .PREADY(), .PSLVERR());
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task check(input [31:0] seen, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task complete_run;
        begin
            $display("checks=%0d mismatches=%0d", n_checks, n_fail);
            if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
            else $display("Finished with errors");
            $finish;
        end
    endtask
    task burst(input w, input c, input [7:0] b);
        begin
            wr_b <= w;
            corr_b <= c;
            base_b <= b;
            go <= 1'b1;
            @(posedge mclk);
            go <= 1'b0;
        end
    endtask
    // waits for the first result of either build; a hang counts as a mismatch
    task wait_res(input par, output integer n);
        begin
            n = 0;
            do begin
                @(posedge mclk);
                n = n + 1;
            end while ((par ? pvld : rvld) !== 1'b1 && n < 40);
            if (n >= 40) begin
                check(0, 1);
                complete_run;
            end
        end
    endtask
    // waits for the first result, then checks three consecutive plane results
    task expect3(input [7:0] e0, input [7:0] e1, input [7:0] e2, input ec, input integer nx);
        integer n;
        begin
            wait_res(1'b0, n);
            check(n, nx);
            check({res_c, res_b, sel_out, res_a}, {18'h0_0000, e0});
            check(corr_out, ec);
            @(posedge mclk);
            check({rvld, sel_out, res_a}, {3'h5, e1});
            @(posedge mclk);
            check({rvld, sel_out, res_a}, {3'h6, e2});
        end
    endtask
    task apb(input w, input [7:0] a, input [31:0] d);
        integer k;
        begin
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge mclk);
            penable <= 1'b1;
            k = 0;
            do begin
                @(posedge mclk);
                k = k + 1;
            end while (pready !== 1'b1 && k < 20);
            if (k >= 20) begin
                check(0, 1);
                complete_run;
            end
            q = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge mclk);
        end
    endtask
    task t_default_table;
        begin
            burst(1'b0, 1'b1, 8'hFF);
            expect3(8'hFF, 8'hFF, 8'hFF, 1'b1, 7);
            burst(1'b0, 1'b1, 8'h00);
            expect3(8'h00, 8'h00, 8'h00, 1'b1, 7);
            $display("test default_table done");
        end
    endtask
    task t_port_write;
        begin
            burst(1'b1, 1'b0, 8'h10);
            repeat (2) @(posedge mclk);
            burst(1'b0, 1'b1, 8'h10);
            expect3(8'hEF, 8'hF0, 8'hF1, 1'b1, 7);
            burst(1'b0, 1'b0, 8'h10);
            expect3(8'h10, 8'h10, 8'h10, 1'b0, 7);
            $display("test port_write done");
        end
    endtask
    task t_freeze;
        begin
            burst(1'b0, 1'b1, 8'hFF);
            repeat (3) @(posedge mclk);
            ce <= 1'b0;
            repeat (5) @(posedge mclk);
            ce <= 1'b1;
            expect3(8'hFF, 8'hFF, 8'hFF, 1'b1, 4);
            $display("test freeze done");
        end
    endtask
    task t_clear;
        integer n_hi;
        begin
            n_hi = 0;
            burst(1'b0, 1'b1, 8'hFF);
            @(posedge mclk);
            clr <= 1'b1;
            repeat (3) @(posedge mclk);
            clr <= 1'b0;
            repeat (12) begin
                @(posedge mclk);
                if (rvld !== 1'b0) n_hi = n_hi + 1;
            end
            check(n_hi, 0);
            $display("test clear done");
        end
    endtask
    task t_apb;
        begin
            apb(1'b0, `GLC_OFF_CONFIG, 32'h0000_0000);
            check(q, 32'h0000_7867);
            check(e, 0);
            apb(1'b0, `GLC_OFF_VALID_COUNT, 32'h0000_0000);
            check(q, 32'h0000_000F);
            apb(1'b0, 8'h20, 32'h0000_0000);
            check(e, 1);
            check(q, 0);
            apb(1'b1, `GLC_OFF_CONTROL, 32'h0000_0002);
            apb(1'b0, `GLC_OFF_CONTROL, 32'h0000_0000);
            check(q, 2);
            burst(1'b0, 1'b1, 8'h10);
            expect3(8'h10, 8'h10, 8'h10, 1'b0, 7);
            apb(1'b1, `GLC_OFF_CONTROL, 32'h0000_0000);
            $display("test apb done");
        end
    endtask
    // lane c carries code 0x10, whose 2.2 gamma entry is 72
    task t_parallel;
        integer n;
        begin
            burst(1'b0, 1'b1, 8'hFF);
            wait_res(1'b1, n);
            check(n, 7);
            check(par_all, {2'h0, 8'h48, 8'h00, 8'hFF, 1'b1});
            repeat (3) @(posedge mclk);
            burst(1'b0, 1'b0, 8'hFF);
            wait_res(1'b1, n);
            check(n, 7);
            check(par_all, {2'h0, 8'h10, 8'h00, 8'hFF, 1'b0});
            $display("test parallel done");
        end
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_default_table;
        t_port_write;
        t_freeze;
        t_clear;
        t_apb;
        t_parallel;
        complete_run;
    end
endmodule

//--- glc_gamma_defines.vh
// register map, field positions and reset values of the gamma corrector
// assumes inclusion by bare name from the design file
`ifndef GLC_GAMMA_DEFINES_VH
`define GLC_GAMMA_DEFINES_VH

// apb byte offsets
`define GLC_OFF_CONFIG 8'h00
`define GLC_OFF_CONTROL 8'h04
`define GLC_OFF_TABLE_WRITE 8'h08
`define GLC_OFF_VALID_COUNT 8'h0C

// control fields
`define GLC_CTRL_CLEAR_BIT 0
`define GLC_CTRL_BYPASS_BIT 1
`define GLC_CTRL_RESET 2'h0

// table write fields
`define GLC_TW_VAL_LSB 0
`define GLC_TW_ADDR_LSB 12
`define GLC_TW_PLANE_LSB 24

// config fields
`define GLC_CFG_SEQ_BIT 0
`define GLC_CFG_PLANES_LSB 1
`define GLC_CFG_LAT_LSB 4
`define GLC_CFG_WIDTH_LSB 8
`define GLC_CFG_BLOCK_BIT 12
`define GLC_CFG_PROG_BIT 13
`define GLC_CFG_BYPASS_BIT 14

`define GLC_COUNT_RESET 32'h0000_0000
`define GLC_WORD_ZERO 32'h0000_0000

// memory style choices and width thresholds
`define GLC_MEM_AUTO 0
`define GLC_MEM_BLOCK 1
`define GLC_MEM_DIST 2
`define GLC_AUTO_BLOCK_MIN_W 7
`define GLC_BLOCK_MIN_W 5
`define GLC_DIST_MAX_W 8

`define GLC_LN2 0.6931471805599453

`endif

//--- glc_pixel_source.sv
// upstream pixel source: one three-plane burst per go pulse on the shared port
// assumes base, wr and corr held steady by the bench for the burst
`timescale 1ns/10ps
module glc_pixel_source (
    // control
    input wire clk,
    input wire go,
    input wire wr,
    input wire corr,
    input wire [7:0] base,
    // stream
    output reg [7:0] sample = 8'h00,
    output reg [1:0] sel = 2'h0,
    output reg valid = 1'b0,
    output reg strobe = 1'b0,
    output reg [7:0] wval = 8'h00,
    output reg corr_en = 1'b0
);
    reg [1:0] left = 2'h0;
    wire [1:0] nsel = go ? 2'h0 : sel + 2'h1;
    always @(posedge clk) begin
        corr_en <= corr;
        if (go || left != 2'h0) begin
            sel <= nsel;
            left <= go ? 2'h2 : left - 2'h1;
            sample <= base;
            valid <= !wr;
            strobe <= wr;
            wval <= ~base + {6'h00, nsel};
        end else begin
            // idle lines toggle so a stale value is never mistaken for data
            sample <= ~sample;
            valid <= 1'b0;
            strobe <= 1'b0;
            wval <= ~wval;
        end
    end
endmodule
